// ==== tb_uct_top.sv ====
/*
 * Testbench of the serial port control block: register port tasks, frame, infrared and interrupt scenarios.
 * Assumes uct_pkg, uct_top and uct_far are compiled before it.
 */
`timescale 1ns/1ps
`include "uct_regs.svh"
module tb_uct_top;
	import uct_pkg::*;
	logic        i_core_clk;
	logic        i_rst_n;
	uct_req_t    bus;
	logic [31:0] rdata;
	logic        rxd;
	logic        txd;
	logic        sir;
	logic        irq;
	logic [31:0] v;
	logic [11:0] g;
	logic        ok;
	int          n_fail = 0;
	int          comparisons = 0;
	int          n_sir = 0;
	int          n_low = 0;
	int          n_hi = 0;
	logic [3:0]  ra [8] = '{`UCT_A_DIV, `UCT_A_LCTL, `UCT_A_CTL, `UCT_A_LVL, `UCT_A_IMSK, `UCT_A_RIS, `UCT_A_MIS, 4'hF};
	logic [31:0] rv [8] = '{32'h0000_0036, 32'h0000_0003, 0, 32'h0000_0022, 0, 0, 0, 0};

	uct_top i_uct_top (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_bus(bus), .o_rdata(rdata),
		.i_rxd(rxd), .i_sir_in(sir), .o_txd(txd), .o_sir_out(sir), .o_irq(irq));
	uct_far #(.P_BIT(16)) i_uct_far (.i_core_clk(i_core_clk), .i_txd(txd), .o_rxd(rxd));

	// ----------------------------------------
	// Clock and line monitors
	// ----------------------------------------
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	always @(posedge sir) n_sir++;
	always @(negedge txd) n_low++;
	always @(posedge i_core_clk) if (sir === 1'b1) n_hi++;

	// ----------------------------------------
	// Register port and checks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge i_core_clk);
		bus.wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_core_clk);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge i_core_clk);
		bus.rd   <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic chk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		cmp($sformatf("register %0h", a), exp, d);
	endtask : chk

	task automatic tx_check(input logic [1:0] wl, input logic [2:0] pa, input logic s2, input logic [7:0] d);
		logic [11:0] e;
		logic [7:0]  dm;
		int          n;
		e = '1;
		e[0] = 1'b0;
		dm = d & ~(8'hFF << (5 + wl));
		for (int i = 0; i < 5 + wl; i++) e[1 + i] = d[i];
		n = 6 + wl;
		if (pa != PAR_OFF) begin
			e[n] = (pa == PAR_EVEN) ? ^dm : (pa == PAR_ODD) ? ~^dm : (pa == PAR_HIGH);
			n++;
		end
		wr(`UCT_A_LCTL, {25'h0, 1'b1, pa, s2, wl});
		wr(`UCT_A_DATA, {24'h0, d});
		i_uct_far.grab(g, ok, n + 1 + int'(s2));
		cmp("tx start", 32'h0000_0001, {31'h0, ok});
		cmp("tx frame", {20'h0, e}, {20'h0, g});
	endtask : tx_check

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	initial begin
		repeat (100000) @(posedge i_core_clk);
		n_fail++;
		complete_run();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		bus = '0;
		i_rst_n = 1'b0;
		repeat (8) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		foreach (ra[i]) chk(ra[i], rv[i]);
		for (int w = 0; w < 4; w++) for (int p = 0; p < 5; p++) begin
			wr(`UCT_A_LCTL, 32'(p * 8 + (w % 2) * 4 + w));
			chk(`UCT_A_LCTL, 32'(p * 8 + (w % 2) * 4 + w));
		end
		for (int t = 0; t < 5; t++) begin
			wr(`UCT_A_LVL, 32'((4 - t) * 16 + t));
			chk(`UCT_A_LVL, 32'((4 - t) * 16 + t));
		end
		wr(`UCT_A_DIV, 32'h0000_1234);
		chk(`UCT_A_DIV, 32'h0000_1234);
		wr(`UCT_A_DIV, 32'h0000_0001);
		wr(`UCT_A_CTL, 32'h0000_0007);
		tx_check(2'd3, 3'd1, 1'b1, 8'hA5);
		tx_check(2'd0, 3'd2, 1'b0, 8'h1F);
		tx_check(2'd2, 3'd3, 1'b0, 8'h00);
		tx_check(2'd1, 3'd4, 1'b1, 8'h3F);
		wr(`UCT_A_LCTL, 32'h0000_004B);
		wr(`UCT_A_IMSK, 32'h0000_0004);
		i_uct_far.send(12'h478, 11);
		chk(`UCT_A_DATA, 32'h0000_003C);
		i_uct_far.send(12'h278, 11);
		chk(`UCT_A_DATA, 32'h0000_033C);
		rd(`UCT_A_RIS, v);
		cmp("raw status", 32'h0000_000C, v & 32'h0000_000C);
		chk(`UCT_A_MIS, 32'h0000_0004);
		cmp("irq set", 32'h0000_0001, {31'h0, irq});
		wr(`UCT_A_ICR, 32'h0000_0004);
		rd(`UCT_A_RIS, v);
		cmp("raw after clear", 32'h0000_0008, v & 32'h0000_000C);
		cmp("irq masked", 32'h0000_0000, {31'h0, irq});
		wr(`UCT_A_LCTL, 32'h0000_0043);
		n_sir = 0;
		n_low = 0;
		wr(`UCT_A_CTL, 32'h0000_000F);
		wr(`UCT_A_DATA, 32'h0000_0000);
		repeat (220) @(posedge i_core_clk);
		cmp("ir pulses", 32'd9, 32'(n_sir));
		cmp("ir txd idle", 32'd0, 32'(n_low));
		rd(`UCT_A_FLAG, v);
		cmp("ir loopback received", 32'h0000_0000, v & 32'h0000_0010);
		chk(`UCT_A_DATA, 32'h0000_0000);
		wr(`UCT_A_DIV, 32'h0000_0010);
		wr(`UCT_A_CTL, 32'h0000_001F);
		n_sir = 0;
		n_hi = 0;
		wr(`UCT_A_DATA, 32'h0000_0000);
		repeat (2800) @(posedge i_core_clk);
		cmp("lp pulses", 32'd9, 32'(n_sir));
		cmp("lp high clocks", 32'd1467, 32'(n_hi));
		wr(`UCT_A_DIV, 32'h0000_0001);
		wr(`UCT_A_CTL, 32'h0000_0007);
		n_sir = 0;
		tx_check(2'd3, 3'd0, 1'b0, 8'h5A);
		cmp("plain no ir", 32'd0, 32'(n_sir));
		fork
			i_uct_far.grab(g, ok, 10);
			begin
				wr(`UCT_A_DATA, 32'h0000_00C3);
				wr(`UCT_A_DATA, 32'h0000_003C);
				repeat (4) @(posedge i_core_clk);
				wr(`UCT_A_CTL, 32'h0000_0000);
			end
		join
		cmp("frame finishes", 32'h0000_0F86, {20'h0, g});
		n_low = 0;
		repeat (100) @(posedge i_core_clk);
		cmp("no new frame", 32'd0, 32'(n_low));
		wr(`UCT_A_LCTL, 32'h0000_0003);
		rd(`UCT_A_FLAG, v);
		cmp("tx flushed", 32'h0000_0004, v & 32'h0000_0005);
		wr(`UCT_A_LCTL, 32'h0000_0043);
		wr(`UCT_A_LVL, 32'h0000_0000);
		repeat (3) wr(`UCT_A_DATA, 32'h0000_0055);
		rd(`UCT_A_RIS, v);
		cmp("tx level above", 32'h0000_0000, v & 32'h0000_0020);
		wr(`UCT_A_CTL, 32'h0000_0007);
		repeat (4) @(posedge i_core_clk);
		rd(`UCT_A_RIS, v);
		cmp("tx level reached", 32'h0000_0020, v & 32'h0000_0020);
		complete_run();
	end
endmodule : tb_uct_top

// ==== uct_baud.sv ====
/*
 * Baud generator: one tick per divisor periods of the core clock, sixteen ticks per bit.
 * Assumes the core clock is also the processor clock.
 */
`timescale 1ns/1ps
module uct_baud (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic [15:0] i_div,
	output logic             o_tick
);
	logic [15:0] cnt_q;

	// Divisor 0 behaves as 1
	assign o_tick = ({1'b0, cnt_q} + 17'h0_0001) >= {1'b0, i_div};

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n)
			cnt_q <= 16'h0000;
		else if (i_ce)
			cnt_q <= o_tick ? 16'h0000 : 16'(cnt_q + 16'h0001);
	end
endmodule : uct_baud

// ==== uct_far.sv ====
/*
 * Remote serial transceiver: sends frames on the receive line, captures frames from the transmit line.
 * Assumes one bit lasts P_BIT core clocks, set by the bench from its divisor.
 */
`timescale 1ns/1ps
module uct_far #(
	parameter int P_BIT = 16
) (
	input  wire logic i_core_clk,
	input  wire logic i_txd,
	output logic      o_rxd
);
	// ----------------------------------------
	// Line idles high between frames
	// ----------------------------------------
	initial o_rxd = 1'b1;

	// Bits go out LSB first: start, data, parity, stop
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_core_clk);
			o_rxd <= bits[i];
			repeat (P_BIT - 1) @(posedge i_core_clk);
		end
		@(posedge i_core_clk);
		o_rxd <= 1'b1;
	endtask : send

	// Waits for a start bit, then samples each bit in its middle
	task automatic grab(output logic [11:0] bits, output logic ok, input int n);
		bits = '1;
		// Falling edge keeps the sample clear of the edge that launches the line
		for (int k = 0; k < 400 && i_txd !== 1'b0; k++) @(negedge i_core_clk);
		ok = (i_txd === 1'b0);
		repeat (P_BIT / 2) @(negedge i_core_clk);
		for (int i = 0; i < n; i++) begin
			bits[i] = i_txd;
			repeat (P_BIT) @(negedge i_core_clk);
		end
	endtask : grab
endmodule : uct_far

// ==== uct_fifo.sv ====
/*
 * Sixteen-entry FIFO memory with registered read data.
 * Assumes the caller never pushes when full nor pops when empty.
 */
`timescale 1ns/1ps
`include "uct_regs.svh"
module uct_fifo #(
	parameter int W = 8
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_ce,
	input  wire logic         i_flush,
	input  wire logic         i_push,
	input  wire logic [W-1:0] i_wdata,
	input  wire logic         i_pop,
	output logic      [W-1:0] o_rdata,
	output logic      [4:0]   o_count
);
	logic [W-1:0] mem_q [`UCT_DEPTH];
	logic [3:0]   wptr_q;
	logic [3:0]   rptr_q;
	logic [4:0]   cnt_q;
	logic [4:0]   cnt_d;

	assign cnt_d   = 5'(cnt_q + {4'h0, i_push} - {4'h0, i_pop});
	assign o_count = cnt_q;

	always_ff @(posedge i_core_clk) begin
		if (i_ce && i_push && !i_flush)
			mem_q[wptr_q] <= i_wdata;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			wptr_q  <= 4'h0;
			rptr_q  <= 4'h0;
			cnt_q   <= 5'h00;
			o_rdata <= '0;
		end else if (i_ce) begin
			if (i_flush) begin
				wptr_q <= 4'h0;
				rptr_q <= 4'h0;
				cnt_q  <= 5'h00;
			end else begin
				if (i_push)
					wptr_q <= 4'(wptr_q + 4'h1);
				if (i_pop) begin
					o_rdata <= mem_q[rptr_q];
					rptr_q  <= 4'(rptr_q + 4'h1);
				end
				cnt_q <= cnt_d;
			end
		end
	end
endmodule : uct_fifo

// ==== uct_pkg.sv ====
/*
 * Types of the serial port control block: bus request, frame format, control bits, state codes.
 * Assumes uct_regs.svh is on the include path.
 */
package uct_pkg;
	`include "uct_regs.svh"

	typedef enum logic [2:0] {
		PAR_OFF = 3'h0, PAR_EVEN = 3'h1, PAR_ODD = 3'h2, PAR_HIGH = 3'h3, PAR_LOW = 3'h4
	} uct_par_t;

	typedef struct packed {
		logic     fen;
		uct_par_t par;
		logic     stop2;
		logic [1:0] wlen;
	} uct_fmt_t;

	typedef struct packed {
		logic irlp;
		logic ire;
		logic receive_enable_bit;
		logic transmit_enable_bit;
		logic en;
	} uct_ctl_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} uct_req_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_LOAD = 3'h1, TX_START = 3'h3, TX_DATA = 3'h2, TX_PAR = 3'h6, TX_STOP = 3'h7
	} uct_tx_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_PAR = 3'h2, RX_STOP = 3'h6
	} uct_rx_t;
endpackage : uct_pkg

// ==== uct_regs.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the serial port control block.
 * Assumes a 100 MHz core clock and a word-indexed register port.
 */
`ifndef UCT_REGS_SVH
`define UCT_REGS_SVH

// ----------------------------------------
// Register offsets (word index)
// ----------------------------------------
`define UCT_A_DATA      4'h0
`define UCT_A_FLAG      4'h1
`define UCT_A_DIV       4'h2
`define UCT_A_LCTL      4'h3
`define UCT_A_CTL       4'h4
`define UCT_A_LVL       4'h5
`define UCT_A_IMSK      4'h6
`define UCT_A_RIS       4'h7
`define UCT_A_MIS       4'h8
`define UCT_A_ICR       4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UCT_LVL_TX_LO   0
`define UCT_LVL_RX_LO   4
`define UCT_IRQ_OE      0
`define UCT_IRQ_BE      1
`define UCT_IRQ_PE      2
`define UCT_IRQ_FE      3
`define UCT_IRQ_RT      4
`define UCT_IRQ_TX      5
`define UCT_IRQ_RX      6
`define UCT_NIRQ        7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UCT_RST_DIV     16'h0036
`define UCT_RST_LCTL    7'h03
`define UCT_RST_CTL     5'h00
`define UCT_RST_LVL     3'h2
`define UCT_RST_IMSK    7'h00

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define UCT_DEPTH       16
`define UCT_RXW         12
`define UCT_TXW         8
`define UCT_CLK_MHZ     100
`define UCT_SIR_LP_NS   1630
`define UCT_SIR_LP_CYC  ((`UCT_SIR_LP_NS * `UCT_CLK_MHZ + 999) / 1000)
`define UCT_TMO_TICKS   (32 * 16)
`define UCT_SIR_STRETCH 10

`endif

// ==== uct_top.sv ====
/*
 * Serial port control block: frame format, baud divisor, enables, infrared mode, FIFO thresholds, interrupts.
 * Assumes synchronous pins, a single core clock and a register port with read data one cycle later.
 */
`timescale 1ns/1ps
`include "uct_regs.svh"
module uct_top (
	input  wire logic            i_core_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_ce,
	input  wire uct_pkg::uct_req_t i_bus,
	output logic     [31:0]      o_rdata,
	input  wire logic            i_rxd,
	input  wire logic            i_sir_in,
	output logic                 o_txd,
	output logic                 o_sir_out,
	output logic                 o_irq
);
	import uct_pkg::*;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [4:0] lvl_count(input logic [2:0] sel);
		case (sel)
			3'h0:    lvl_count = 5'(`UCT_DEPTH * 1 / 8);
			3'h1:    lvl_count = 5'(`UCT_DEPTH * 2 / 8);
			3'h2:    lvl_count = 5'(`UCT_DEPTH * 4 / 8);
			3'h3:    lvl_count = 5'(`UCT_DEPTH * 6 / 8);
			default: lvl_count = 5'(`UCT_DEPTH * 7 / 8);
		endcase
	endfunction : lvl_count

	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wlen, input uct_par_t m);
		logic x;
		x = ^(d & 8'(8'hff >> (2'h3 - wlen)));
		case (m)
			PAR_EVEN: par_bit = x;
			PAR_ODD:  par_bit = ~x;
			PAR_HIGH: par_bit = 1'b1;
			default:  par_bit = 1'b0;
		endcase
	endfunction : par_bit

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	logic [15:0] div_q;
	uct_fmt_t    fmt_q;
	uct_ctl_t    ctl_q;
	logic [2:0]  txlvl_q;
	logic [2:0]  rxlvl_q;
	logic [6:0]  imsk_q;
	logic [6:0]  ris_q;
	logic [6:0]  ris_set;
	logic [31:0] rdata_q;
	logic        data_rd_q;

	wire acc      = i_ce;
	wire wr_data  = acc && i_bus.wr && i_bus.addr == `UCT_A_DATA;
	wire wr_div   = acc && i_bus.wr && i_bus.addr == `UCT_A_DIV;
	wire wr_lctl  = acc && i_bus.wr && i_bus.addr == `UCT_A_LCTL;
	wire wr_ctl   = acc && i_bus.wr && i_bus.addr == `UCT_A_CTL;
	wire wr_lvl   = acc && i_bus.wr && i_bus.addr == `UCT_A_LVL;
	wire wr_imsk  = acc && i_bus.wr && i_bus.addr == `UCT_A_IMSK;
	wire wr_icr   = acc && i_bus.wr && i_bus.addr == `UCT_A_ICR;
	wire rd_data  = acc && i_bus.rd && i_bus.addr == `UCT_A_DATA;
	wire [6:0] mis = ris_q & imsk_q;
	wire [6:0] clr = wr_icr ? i_bus.wdata[6:0] : 7'h00;

	// ----------------------------------------
	// FIFOs and baud tick
	// ----------------------------------------
	logic [4:0]  txcnt;
	logic [4:0]  rxcnt;
	logic [7:0]  tx_head;
	logic [11:0] rx_head;
	logic        tick;
	logic        tx_pop;
	logic        rx_push;
	logic [11:0] rx_word;

	// Without FIFO enable each FIFO holds one entry
	wire tx_full  = fmt_q.fen ? txcnt == 5'(`UCT_DEPTH) : txcnt != 5'h00;
	wire rx_full  = fmt_q.fen ? rxcnt == 5'(`UCT_DEPTH) : rxcnt != 5'h00;
	wire tx_empty = txcnt == 5'h00;
	wire rx_empty = rxcnt == 5'h00;
	wire tx_flush = wr_lctl && fmt_q.fen && !i_bus.wdata[6];
	wire tx_push  = wr_data && !tx_full;
	wire rx_pop   = rd_data && !rx_empty;
	wire rx_ok    = rx_push && !rx_full;

	uct_fifo #(.W(`UCT_TXW)) u_txf (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.i_flush    (tx_flush),
		.i_push     (tx_push),
		.i_wdata    (i_bus.wdata[7:0]),
		.i_pop      (tx_pop),
		.o_rdata    (tx_head),
		.o_count    (txcnt)
	);

	uct_fifo #(.W(`UCT_RXW)) u_rxf (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.i_flush    (1'b0),
		.i_push     (rx_ok),
		.i_wdata    (rx_word),
		.i_pop      (rx_pop),
		.o_rdata    (rx_head),
		.o_count    (rxcnt)
	);

	uct_baud u_baud (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.i_div      (div_q),
		.o_tick     (tick)
	);

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	uct_tx_t    tx_state_q;
	logic [3:0] tx_tk_q;
	logic [2:0] tx_bit_q;
	logic [7:0] tx_sh_q;
	logic       tx_par_q;
	logic       tx_stop2_q;
	logic [7:0] lp_q;

	wire [2:0] last_bit = 3'({1'b0, fmt_q.wlen} + 3'h4);
	wire tx_go    = ctl_q.en && ctl_q.transmit_enable_bit && !tx_empty;
	wire tx_end   = tick && tx_tk_q == 4'hf;
	wire tx_line  = (tx_state_q == TX_START) ? 1'b0 :
	                (tx_state_q == TX_DATA)  ? tx_sh_q[0] :
	                (tx_state_q == TX_PAR)   ? tx_par_q : 1'b1;
	wire tx_busy  = tx_state_q != TX_IDLE;
	wire bit_open = tx_state_q == TX_LOAD || (tx_end && tx_busy);
	wire sir_pls  = ctl_q.irlp ? lp_q != 8'h00 : tx_tk_q < 4'h3;
	assign tx_pop = i_ce && tx_state_q == TX_IDLE && tx_go;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			tx_state_q <= TX_IDLE;
			tx_tk_q    <= 4'h0;
			tx_bit_q   <= 3'h0;
			tx_sh_q    <= 8'h00;
			tx_par_q   <= 1'b0;
			tx_stop2_q <= 1'b0;
		end else if (i_ce) begin
			if (tick || tx_state_q == TX_LOAD)
				tx_tk_q <= (tx_state_q == TX_LOAD) ? 4'h0 : 4'(tx_tk_q + 4'h1);
			unique case (tx_state_q)
				TX_IDLE: if (tx_go) tx_state_q <= TX_LOAD;
				TX_LOAD: begin
					tx_sh_q    <= tx_head;
					tx_par_q   <= par_bit(tx_head, fmt_q.wlen, fmt_q.par);
					tx_bit_q   <= 3'h0;
					tx_stop2_q <= 1'b0;
					tx_state_q <= TX_START;
				end
				TX_START: if (tx_end) tx_state_q <= TX_DATA;
				TX_DATA: if (tx_end) begin
					tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
					tx_bit_q <= 3'(tx_bit_q + 3'h1);
					if (tx_bit_q == last_bit)
						tx_state_q <= (fmt_q.par == PAR_OFF) ? TX_STOP : TX_PAR;
				end
				TX_PAR: if (tx_end) tx_state_q <= TX_STOP;
				TX_STOP: if (tx_end) begin
					if (fmt_q.stop2 && !tx_stop2_q)
						tx_stop2_q <= 1'b1;
					else
						tx_state_q <= TX_IDLE;
				end
				default: tx_state_q <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			lp_q      <= 8'h00;
			o_txd     <= 1'b1;
			o_sir_out <= 1'b0;
		end else if (i_ce) begin
			lp_q      <= bit_open ? 8'(`UCT_SIR_LP_CYC) : (lp_q != 8'h00 ? 8'(lp_q - 8'h01) : 8'h00);
			o_txd     <= ctl_q.ire ? 1'b1 : tx_line;
			o_sir_out <= ctl_q.ire && tx_busy && !tx_line && sir_pls;
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	uct_rx_t    rx_state_q;
	logic [3:0] rx_tk_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic       rx_pb_q;
	logic [3:0] str_q;
	logic [9:0] tmo_q;

	wire rx_line  = ctl_q.ire ? !(i_sir_in || str_q != 4'h0) : i_rxd;
	wire rx_on    = ctl_q.en && ctl_q.receive_enable_bit;
	wire rx_mid   = tick && rx_tk_q == 4'h7;
	wire rx_smp   = tick && rx_tk_q == 4'hf;
	wire rx_pe    = fmt_q.par != PAR_OFF && rx_pb_q != par_bit(rx_sh_q, fmt_q.wlen, fmt_q.par);
	wire rx_be    = rx_sh_q == 8'h00 && !rx_line && (fmt_q.par == PAR_OFF || !rx_pb_q);
	assign rx_word = {rx_full, rx_be, rx_pe, !rx_line, rx_sh_q};
	assign rx_push = i_ce && rx_state_q == RX_STOP && rx_smp;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rx_state_q <= RX_IDLE;
			rx_tk_q    <= 4'h0;
			rx_bit_q   <= 3'h0;
			rx_sh_q    <= 8'h00;
			rx_pb_q    <= 1'b0;
			str_q      <= 4'h0;
		end else if (i_ce) begin
			if (i_sir_in)
				str_q <= 4'(`UCT_SIR_STRETCH);
			else if (tick && str_q != 4'h0)
				str_q <= 4'(str_q - 4'h1);
			if (tick)
				rx_tk_q <= (rx_state_q == RX_IDLE || rx_mid && rx_state_q == RX_START) ? 4'h0 : 4'(rx_tk_q + 4'h1);
			unique case (rx_state_q)
				RX_IDLE: if (tick && rx_on && !rx_line) begin
					rx_state_q <= RX_START;
					rx_sh_q    <= 8'h00;
					rx_bit_q   <= 3'h0;
				end
				RX_START: if (rx_mid) rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
				RX_DATA: if (rx_smp) begin
					rx_sh_q[rx_bit_q] <= rx_line;
					rx_bit_q          <= 3'(rx_bit_q + 3'h1);
					if (rx_bit_q == last_bit)
						rx_state_q <= (fmt_q.par == PAR_OFF) ? RX_STOP : RX_PAR;
				end
				RX_PAR: if (rx_smp) begin
					rx_pb_q    <= rx_line;
					rx_state_q <= RX_STOP;
				end
				RX_STOP: if (rx_smp) rx_state_q <= RX_IDLE;
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// Idle-line timeout with data waiting
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n)
			tmo_q <= 10'h000;
		else if (i_ce) begin
			if (rx_state_q != RX_IDLE || rx_empty || rx_pop)
				tmo_q <= 10'h000;
			else if (tick && tmo_q != 10'(`UCT_TMO_TICKS))
				tmo_q <= 10'(tmo_q + 10'h001);
		end
	end

	// ----------------------------------------
	// Interrupt sources
	// ----------------------------------------
	logic tx_cond_q;
	logic rx_cond_q;

	wire tx_cond = txcnt <= lvl_count(txlvl_q);
	wire rx_cond = rxcnt >= lvl_count(rxlvl_q);
	wire tmo_hit = tick && tmo_q == 10'(`UCT_TMO_TICKS - 1);

	// Source bits in register order, receive level first, overrun last
	assign ris_set = {rx_cond && !rx_cond_q, tx_cond && !tx_cond_q, tmo_hit,
	                  rx_push && !rx_line, rx_push && rx_pe, rx_push && rx_be,
	                  rx_push && rx_full};

	// ----------------------------------------
	// Register storage and read mux
	// ----------------------------------------
	wire [31:0] rd_mux =
		(i_bus.addr == `UCT_A_FLAG) ? {27'h000_0000, rx_empty, rx_full, tx_empty, tx_full, tx_busy} :
		(i_bus.addr == `UCT_A_DIV)  ? {16'h0000, div_q} :
		(i_bus.addr == `UCT_A_LCTL) ? {25'h000_0000, fmt_q} :
		(i_bus.addr == `UCT_A_CTL)  ? {27'h000_0000, ctl_q} :
		(i_bus.addr == `UCT_A_LVL)  ? {25'h000_0000, rxlvl_q, 1'b0, txlvl_q} :
		(i_bus.addr == `UCT_A_IMSK) ? {25'h000_0000, imsk_q} :
		(i_bus.addr == `UCT_A_RIS)  ? {25'h000_0000, ris_q} :
		(i_bus.addr == `UCT_A_MIS)  ? {25'h000_0000, mis} : 32'h0000_0000;

	assign o_rdata = data_rd_q ? {20'h0_0000, rx_head} : rdata_q;
	assign o_irq   = |mis;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			div_q     <= `UCT_RST_DIV;
			fmt_q     <= `UCT_RST_LCTL;
			ctl_q     <= `UCT_RST_CTL;
			txlvl_q   <= `UCT_RST_LVL;
			rxlvl_q   <= `UCT_RST_LVL;
			imsk_q    <= `UCT_RST_IMSK;
			ris_q     <= 7'h00;
			tx_cond_q <= 1'b1;
			rx_cond_q <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			data_rd_q <= 1'b0;
		end else if (i_ce) begin
			if (wr_div)  div_q  <= i_bus.wdata[15:0];
			if (wr_lctl) fmt_q  <= i_bus.wdata[6:0];
			if (wr_ctl)  ctl_q  <= i_bus.wdata[4:0];
			if (wr_lvl) begin
				txlvl_q <= i_bus.wdata[`UCT_LVL_TX_LO +: 3];
				rxlvl_q <= i_bus.wdata[`UCT_LVL_RX_LO +: 3];
			end
			if (wr_imsk) imsk_q <= i_bus.wdata[6:0];
			ris_q     <= (ris_q & ~clr) | ris_set;
			tx_cond_q <= tx_cond;
			rx_cond_q <= rx_cond;
			rdata_q   <= i_bus.rd ? rd_mux : 32'h0000_0000;
			data_rd_q <= rd_data;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	a_irq_masked_off: assert property (wr_imsk |=> o_irq == |(ris_q & $past(i_bus.wdata[6:0])))
		else $error("masked source drove irq");
	a_clear_selected: assert property (wr_icr |=> (ris_q & $past(i_bus.wdata[6:0]) & ~$past(ris_set)) == 7'h00)
		else $error("selected source not cleared");
	a_clear_others: assert property (wr_icr |=> (ris_q & ~$past(i_bus.wdata[6:0])) ==
		(($past(ris_q) | $past(ris_set)) & ~$past(i_bus.wdata[6:0]))) else $error("unselected source changed");
	a_masked_read: assert property (acc && i_bus.rd && i_bus.addr == `UCT_A_MIS |=> o_rdata[6:0] == $past(mis))
		else $error("masked status read wrong");
	a_format_read: assert property (acc && i_bus.rd && i_bus.addr == `UCT_A_LCTL |=> o_rdata[6:0] == $past(fmt_q))
		else $error("format readback wrong");
	a_level_read: assert property (acc && i_bus.rd && i_bus.addr == `UCT_A_LVL |=>
		o_rdata[2:0] == $past(txlvl_q) && o_rdata[6:4] == $past(rxlvl_q)) else $error("threshold readback wrong");
	a_plain_no_pulse: assert property (i_ce && !ctl_q.ire |=> !o_sir_out) else $error("pulse outside infrared mode");
	a_ir_txd_idle: assert property (i_ce && ctl_q.ire |=> o_txd) else $error("plain line active in infrared mode");
	a_parity_out: assert property (i_ce && tx_state_q == TX_PAR && !ctl_q.ire |=> o_txd == $past(tx_par_q))
		else $error("parity bit wrong");
	a_stop_high: assert property (i_ce && tx_state_q == TX_STOP && !ctl_q.ire |=> o_txd) else $error("stop bit low");
	a_tx_held: assert property (tx_state_q == TX_IDLE && !(ctl_q.en && ctl_q.transmit_enable_bit) |=> tx_state_q == TX_IDLE)
		else $error("sent while disabled");
	a_bit_limit: assert property (tx_state_q == TX_DATA |-> tx_bit_q <= last_bit) else $error("too many data bits");
	a_tx_level_irq: assert property (i_ce && tx_cond && !tx_cond_q |=> ris_q[`UCT_IRQ_TX])
		else $error("transmit level source missed");

	c_frame_sent: cover property (tx_state_q == TX_STOP ##1 tx_state_q == TX_IDLE);
	c_char_recv: cover property (rx_ok);
	c_irq_raised: cover property (!o_irq ##1 o_irq);
endmodule : uct_top
